// ===== dv/mgmt_host.sv
`timescale 1ns/1ps
// Idles on an unmapped address with inverted data, never holding the last word
module mgmt_host(input wire ref_clk,input wire [15:0] reg_rdata,output reg [4:0] reg_addr=5'h06,
    output reg reg_write=0,output reg reg_read=0,output reg [15:0] reg_wdata=0);
task wr(input [15:0] d);
    @(posedge ref_clk) #1 {reg_addr,reg_write,reg_wdata}={6'h33,d&16'h0DFF};
    @(posedge ref_clk) #1 {reg_addr,reg_write,reg_wdata}={6'h0C,~d};
endtask
task rd(output [15:0] q);
    @(posedge ref_clk) #1 {reg_addr,reg_read}=6'h33;
    @(posedge ref_clk) #1 {reg_addr,reg_read}=6'h0C;
    q=reg_rdata;
endtask
endmodule

// ===== dv/phy_address_status_assertions.sv
`timescale 1ns/1ps
module phy_chk(input wire ref_clk,reset,repeater_strap,autoneg_enable_ctrl,full_duplex_now,
    speed_10_now,indicator_one_select,carrier_unstable,descrambler_locked,reg_read,
    indicator_one_pin,far_end_fault_indication,isolate_request,
    input wire [4:0] reg_addr,phy_address_straps,phy_address_field,input wire [15:0] reg_rdata);
default clocking @(posedge ref_clk); endclocking
default disable iff (reset);
sequence rd; reg_read&&reg_addr==5'h19; endsequence
a_speed_flag: assert property(rd|=>reg_rdata[6]==$past(speed_10_now))else $error("s");
a_duplex_flag: assert property(rd|=>reg_rdata[7]==$past(full_duplex_now))else $error("d");
a_autoneg_flag: assert property(rd##0 autoneg_enable_ctrl|=>reg_rdata[10])
    else $error("a");
a_flag_held: assert property(carrier_unstable##1 !(reg_read&&reg_addr==5'h19)
    ##1 rd|=>reg_rdata[5])else $error("carrier flag lost before read");
a_led_route: assert property(carrier_unstable##1 indicator_one_select[*2]|->
    indicator_one_pin)else $error("i");
a_addr_strap: assert property($fell(reset)|=>isolate_request==(phy_address_field==5'h00)&&
    phy_address_field==$past(phy_address_straps))else $error("p");
a_jab_default: assert property($fell(reset)##1 rd|=>reg_rdata[11]!=repeater_strap)
    else $error("j");
a_fault_off: assert property(descrambler_locked|=>!far_end_fault_indication)
    else $error("f");
endmodule
bind phy_address_status phy_chk chk(.*);

// ===== dv/testbench.sv
`timescale 1ns/1ps
module testbench;
reg ref_clk=0,reset=1,repeater_strap=0,autoneg_strap_zero=0,autoneg_strap_one=0,speed_10_now=0;
reg autoneg_enable_ctrl=0,full_duplex_now=0,indicator_one_select=0,indicator_one_default=0;
reg carrier_unstable=0,receive_active=0,descrambler_timeout=0,descrambler_locked=1;
reg [4:0] phy_address_straps=0;
reg [15:0] q;
wire [4:0] reg_addr,phy_address_field;
wire reg_write,reg_read,carrier_sense,indicator_one_pin,far_end_fault_indication,isolate_request;
wire [15:0] reg_wdata,reg_rdata;
integer fails=0,samples_checked=0,i;
phy_address_status uut(.*);
mgmt_host host(.*);
initial forever #12.5 ref_clk=~ref_clk;
task chk(input [15:0] s,e,input [23:0] n);
    samples_checked=samples_checked+1;
    if(s!==e)begin fails=fails+1; $display("Error %s exp %h seen %h",n,e,s); end
endtask
task test_done;
    $display("fails %0d samples_checked %0d",fails,samples_checked);
    if(fails==0&&samples_checked>0)$display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
endtask
task rst(input r,input [4:0] a);
    @(posedge ref_clk) #1 {reset,repeater_strap,phy_address_straps}={1'b1,r,a};
    repeat(2) @(posedge ref_clk);
    #1 reset=0;
    host.rd(q);
    chk({q[11:10],q[8:0]},{!r,5'h00,a},"rst");
endtask
task tmo(input e);
    descrambler_timeout=1;
    @(posedge ref_clk) #1 descrambler_timeout=0;
    repeat(2) @(posedge ref_clk);
    #1 chk(carrier_sense,e,"crs");
endtask
task t_jab;
    {receive_active,descrambler_locked}=2'b10;
    tmo(1);
    host.wr(16'h0915);
    tmo(0);
    chk(far_end_fault_indication,1,"ffi");
endtask
task t_cim;
    indicator_one_default=1;
    @(posedge ref_clk) #1 chk(indicator_one_pin,1,"dfl");
    {indicator_one_select,carrier_unstable}=2'b11;
    @(posedge ref_clk) #1 carrier_unstable=0;
    host.rd(q);
    chk(q[5],1,"cim");
    chk(indicator_one_pin,1,"led");
    host.rd(q);
    chk(q[5],0,"cim");
endtask
task t_mode;
    for(i=0;i<8;i=i+1)begin
        {autoneg_enable_ctrl,full_duplex_now,speed_10_now}=i[2:0];
        host.rd(q);
        chk({q[10],q[7:6]},i[2:0],"mod");
    end
    {autoneg_enable_ctrl,autoneg_strap_one}=2'b01;
    host.rd(q);
    chk(q[10],1,"an1");
    {autoneg_strap_one,autoneg_strap_zero}=2'b01;
    host.rd(q);
    chk(q[10],1,"an0");
endtask
initial begin
    rst(1,5'h15); $display("t1 end");
    t_jab; $display("t2 end");
    t_cim; $display("t3 end");
    rst(0,5'h00); $display("t4 end");
    t_mode; $display("t5 end");
    test_done;
end
initial begin
    #20000 fails=fails+1;
    test_done;
end
endmodule

// ===== hdl/phy_address_status.v
`timescale 1ns/1ps
`include "phy_address_status_regs.vh"
module phy_address_status (
    input wire ref_clk,
    input wire reset,
    input wire repeater_strap,
    input wire [4:0] phy_address_straps,
    input wire autoneg_strap_zero,
    input wire autoneg_strap_one,
    input wire autoneg_enable_ctrl,
    input wire full_duplex_now,
    input wire speed_10_now,
    input wire indicator_one_select,
    input wire indicator_one_default,
    input wire carrier_unstable,
    input wire receive_active,
    input wire descrambler_timeout,
    input wire descrambler_locked,
    input wire [4:0] reg_addr,
    input wire reg_write,
    input wire reg_read,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    output reg carrier_sense,
    output reg indicator_one_pin,
    output reg far_end_fault_indication,
    output reg isolate_request,
    output reg [4:0] phy_address_field
);

// ==========================================
// Register state
reg reset_seen_q;
reg reset_seen_d;
reg jabber_carrier_drop_q;
reg jabber_carrier_drop_d;
reg far_end_fault_enable_q;
reg far_end_fault_enable_d;
reg carrier_integrity_flag_q;
reg carrier_integrity_flag_d;
reg timed_out_q;
reg timed_out_d;
reg isolate_request_d;
reg carrier_sense_d;
reg indicator_one_pin_d;
reg far_end_fault_indication_d;
reg [15:0] reg_rdata_d;
wire [4:0] phy_address_d;
wire hit;
wire read_hit;
wire write_hit;
wire strap_capture;
wire autoneg_enabled_flag;
wire [15:0] read_value;

// ==========================================
// Decode
assign hit = (reg_addr == `PHY_ADDRESS_AND_STATUS_OFFSET);
assign read_hit = reg_read & hit;
assign write_hit = reg_write & hit;

// Straps settle during reset, so the first free edge takes them
assign strap_capture = ~reset_seen_q;

// Either strap or the control bit turns negotiation on
assign autoneg_enabled_flag = autoneg_strap_zero | autoneg_strap_one
    | autoneg_enable_ctrl;

// ==========================================
// Read image
// Reserved bits read zero; software must not rely on them
assign read_value = {4'h0, jabber_carrier_drop_q, autoneg_enabled_flag, 1'h0,
    far_end_fault_enable_q, full_duplex_now, speed_10_now, carrier_integrity_flag_q,
    phy_address_field};

// ==========================================
// Address field, one slice per strap pin
genvar addr_bit;
generate
    for (addr_bit = `PHY_ADDRESS_LSB; addr_bit <= `PHY_ADDRESS_MSB;
            addr_bit = addr_bit + 1) begin : address_bit
        // Strap capture wins over a write in the same cycle
        assign phy_address_d[addr_bit] = strap_capture ? phy_address_straps[addr_bit]
            : (write_hit ? reg_wdata[addr_bit] : phy_address_field[addr_bit]);
    end
endgenerate

// ==========================================
// Control fields, next values
always @* begin
    reset_seen_d = 1'h1;
    jabber_carrier_drop_d = jabber_carrier_drop_q;
    far_end_fault_enable_d = far_end_fault_enable_q;
    isolate_request_d = isolate_request;
    if (strap_capture) begin
        jabber_carrier_drop_d = ~repeater_strap;
        isolate_request_d = (phy_address_straps == `ISOLATE_ADDRESS);
    end else if (write_hit) begin
        jabber_carrier_drop_d = reg_wdata[`JABBER_CARRIER_DROP_BIT];
        far_end_fault_enable_d = reg_wdata[`FAR_END_FAULT_ENABLE_BIT];
    end
end

// ==========================================
// Control fields, registers
always @(posedge ref_clk) begin
    if (reset) begin
        reset_seen_q <= 1'h0;
        jabber_carrier_drop_q <= 1'h0;
        far_end_fault_enable_q <= `FAR_END_FAULT_ENABLE_RESET;
    end else begin
        reset_seen_q <= reset_seen_d;
        jabber_carrier_drop_q <= jabber_carrier_drop_d;
        far_end_fault_enable_q <= far_end_fault_enable_d;
    end
end

always @(posedge ref_clk) begin
    if (reset) begin
        phy_address_field <= `PHY_ADDRESS_RESET;
        isolate_request <= 1'h0;
    end else begin
        phy_address_field <= phy_address_d;
        isolate_request <= isolate_request_d;
    end
end

// ==========================================
// Latched carrier flag
// A new event beats the read clear, so no instability is lost
always @* begin
    carrier_integrity_flag_d = carrier_integrity_flag_q;
    if (carrier_unstable) begin
        carrier_integrity_flag_d = 1'h1;
    end else if (read_hit) begin
        carrier_integrity_flag_d = 1'h0;
    end
end

always @(posedge ref_clk) begin
    if (reset) begin
        carrier_integrity_flag_q <= `CARRIER_INTEGRITY_RESET;
    end else begin
        carrier_integrity_flag_q <= carrier_integrity_flag_d;
    end
end

// ==========================================
// Descrambler time-out memory
always @* begin
    timed_out_d = timed_out_q;
    if (descrambler_locked || !receive_active) begin
        timed_out_d = 1'h0;
    end else if (descrambler_timeout) begin
        timed_out_d = 1'h1;
    end
end

always @(posedge ref_clk) begin
    if (reset) begin
        timed_out_q <= 1'h0;
    end else begin
        timed_out_q <= timed_out_d;
    end
end

// ==========================================
// Carrier sense
// Drop mode cuts carrier at the time-out itself, not a cycle late
always @* begin
    carrier_sense_d = receive_active;
    if (jabber_carrier_drop_q && (descrambler_timeout || timed_out_q)) begin
        carrier_sense_d = 1'h0;
    end
end

always @(posedge ref_clk) begin
    if (reset) begin
        carrier_sense <= 1'h0;
    end else begin
        carrier_sense <= carrier_sense_d;
    end
end

// ==========================================
// Read data
// Data stands one cycle only; idle reads show zero
always @* begin
    reg_rdata_d = 16'h0000;
    if (read_hit) begin
        reg_rdata_d = read_value;
    end
end

always @(posedge ref_clk) begin
    if (reset) begin
        reg_rdata <= 16'h0000;
    end else begin
        reg_rdata <= reg_rdata_d;
    end
end

// ==========================================
// Indicator pin
always @* begin
    indicator_one_pin_d = indicator_one_default;
    if (indicator_one_select) begin
        indicator_one_pin_d = carrier_integrity_flag_q;
    end
end

always @(posedge ref_clk) begin
    if (reset) begin
        indicator_one_pin <= 1'h0;
    end else begin
        indicator_one_pin <= indicator_one_pin_d;
    end
end

// ==========================================
// Far-end fault
// Only loss of lock is seen here; the line code is sent elsewhere
always @* begin
    far_end_fault_indication_d = far_end_fault_enable_q & ~descrambler_locked;
end

always @(posedge ref_clk) begin
    if (reset) begin
        far_end_fault_indication <= 1'h0;
    end else begin
        far_end_fault_indication <= far_end_fault_indication_d;
    end
end

endmodule

// ===== hdl/phy_address_status_regs.vh
`ifndef PHY_ADDRESS_STATUS_REGS_VH
`define PHY_ADDRESS_STATUS_REGS_VH
// ==========================================
// Register offset and field positions
`define PHY_ADDRESS_AND_STATUS_OFFSET 5'h19
`define JABBER_CARRIER_DROP_BIT 11
`define AUTONEG_ENABLED_BIT 10
`define FAR_END_FAULT_ENABLE_BIT 8
`define DUPLEX_FULL_BIT 7
`define SPEED_10_BIT 6
`define CARRIER_INTEGRITY_BIT 5
`define PHY_ADDRESS_MSB 4
`define PHY_ADDRESS_LSB 0
// ==========================================
// Reset values and isolate address
`define FAR_END_FAULT_ENABLE_RESET 1'h0
`define CARRIER_INTEGRITY_RESET 1'h0
`define PHY_ADDRESS_RESET 5'h00
`define ISOLATE_ADDRESS 5'h00
`endif
